// ---- design/atr_pkg.sv ----
// constants and types shared by the two-wire readout sequencer
package atr_pkg;

   // ----------------------------------------------------------------
   // system clock
   // ----------------------------------------------------------------
   localparam longint CLK_HZ          = 20_000_000;

   // ----------------------------------------------------------------
   // result format
   // ----------------------------------------------------------------
   localparam int     DATA_W          = 24;
   localparam int     CNT_W           = 5;
   localparam logic [CNT_W-1:0] LAST_BIT_EDGE = 5'h18;  // 24th edge shows the last bit

   // ----------------------------------------------------------------
   // output rates in milli-samples per second, one per variant
   // ----------------------------------------------------------------
   localparam longint RATE_A_MSPS     = 120_000;
   localparam longint RATE_B_MSPS     = 13_750;
   localparam longint CONV_CYC_A      = (CLK_HZ * 1000) / RATE_A_MSPS;
   localparam longint CONV_CYC_B      = (CLK_HZ * 1000) / RATE_B_MSPS;

   // ----------------------------------------------------------------
   // self-calibration length and sleep-request hold time
   // ----------------------------------------------------------------
   localparam longint CAL_TIME_MS     = 100;
   localparam longint CAL_CYC_DEF     = (CLK_HZ * CAL_TIME_MS) / 1000;
   localparam longint SLEEP_HOLD_US   = 50;
   localparam longint SLEEP_HOLD_CYC  = (CLK_HZ * SLEEP_HOLD_US + 999_999) / 1_000_000;

   // ----------------------------------------------------------------
   // sequencer states, gray along the readout path
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_CAL    = 3'h0,
      ST_CONV   = 3'h1,
      ST_READY  = 3'h3,
      ST_SHIFT  = 3'h2,
      ST_DONE   = 3'h6,
      ST_PEND26 = 3'h7,
      ST_SLPCAL = 3'h5,
      ST_SLEEP  = 3'h4
   } atr_state_t;

endpackage

// ---- design/atr_sclk_if.sv ----
// shift clock events passed from the synchroniser to the sequencer
`timescale 1ns/100ps
interface atr_sclk_if;
   logic level;
   logic rise;
   logic fall;
   logic long_high;

   modport src
   (
      output level,
      output rise,
      output fall,
      output long_high
   );

   modport dst
   (
      input  level,
      input  rise,
      input  fall,
      input  long_high
   );
endinterface

// ---- design/atr_sclk_sync.sv ----
// shift clock synchroniser, edge finder and long-high detector
`timescale 1ns/100ps
module atr_sclk_sync #(
   parameter int unsigned HOLD_CYC = 32'(atr_pkg::SLEEP_HOLD_CYC)
)(
   input  wire logic  i_ref_clk,
   input  wire logic  i_arst_n,
   input  wire logic  i_sclk,
   atr_sclk_if.src    o_ev
);

   if (HOLD_CYC < 8 || HOLD_CYC > 65535)
   begin : g_bad_hold
      $error("hold count out of range");
   end

   logic        meta;
   logic        sync;
   logic        prev;
   logic [15:0] hold;

   // ----------------------------------------------------------------
   // two-stage synchroniser and edge history
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         meta <= i_sclk;
         sync <= meta;
         prev <= sync;
      end
   end

   // ----------------------------------------------------------------
   // high-phase length, saturating at the hold count
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         hold <= 16'h0000;
      else if (!sync)
         hold <= 16'h0000;
      else if (hold != 16'(HOLD_CYC))
         hold <= hold + 16'h0001;
   end

   assign o_ev.level     = sync;
   assign o_ev.rise      = sync & ~prev;
   assign o_ev.fall      = ~sync & prev;
   assign o_ev.long_high = (hold == 16'(HOLD_CYC));

   chk_long_high_held : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      $rose(o_ev.long_high) |-> $past(sync) && $past(hold) == 16'(HOLD_CYC - 1))
      else $error("long high raised without full hold");

endmodule

// ---- design/atr_timer.sv ----
// conversion and calibration interval timer
`timescale 1ns/100ps
module atr_timer #(
   parameter int unsigned CONV_CYC = 32'(atr_pkg::CONV_CYC_A),
   parameter int unsigned CAL_CYC  = 32'(atr_pkg::CAL_CYC_DEF)
)(
   input  wire logic  i_ref_clk,
   input  wire logic  i_arst_n,
   input  wire logic  i_run,
   input  wire logic  i_start_conv,
   input  wire logic  i_start_cal,
   output logic       o_done
);

   if (CONV_CYC < 2 || CAL_CYC < 2)
   begin : g_bad_cyc
      $error("timer intervals must be at least two cycles");
   end

   logic [31:0] cnt;
   logic [31:0] since;
   logic        cal_run;

   // ----------------------------------------------------------------
   // countdown, reloading the conversion period while it runs freely
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cnt <= 32'(CAL_CYC - 1);
      else if (i_start_cal)
         cnt <= 32'(CAL_CYC - 1);
      else if (i_start_conv)
         cnt <= 32'(CONV_CYC - 1);
      else if (i_run)
      begin
         if (cnt == 32'h0000_0000)
            cnt <= 32'(CONV_CYC - 1);
         else
            cnt <= cnt - 32'h0000_0001;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_done <= 1'b0;
      else
         o_done <= i_run && !i_start_cal && !i_start_conv && cnt == 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // period watch: cycles since the last load, and whether it was a calibration
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         since <= 32'h0000_0000;
      else if (i_start_cal || i_start_conv)
         since <= 32'h0000_0000;
      else if (o_done)
         since <= 32'h0000_0001;
      else if (i_run)
         since <= since + 32'h0000_0001;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cal_run <= 1'b1;
      else if (i_start_cal)
         cal_run <= 1'b1;
      else if (i_start_conv || o_done)
         cal_run <= 1'b0;
   end

   chk_conv_period : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_done && !cal_run |-> since == CONV_CYC)
      else $error("conversion period differs from the set count");

   chk_period_exact : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_start_conv ##1 (i_run && !i_start_cal && !i_start_conv) [*2] |-> !o_done)
      else $error("conversion done too early after restart");

endmodule

// ---- design/atr_top.sv ----
// two-wire readout and control sequencer of a 24-bit converter
`timescale 1ns/100ps
module atr_top #(
   parameter int unsigned CONV_CYC = 32'(atr_pkg::CONV_CYC_A),
   parameter int unsigned CAL_CYC  = 32'(atr_pkg::CAL_CYC_DEF),
   parameter int unsigned HOLD_CYC = 32'(atr_pkg::SLEEP_HOLD_CYC)
)(
   input  wire logic                        i_ref_clk,
   input  wire logic                        i_arst_n,
   input  wire logic                        i_sclk,
   input  wire logic                        i_ext_clk_det,
   input  wire logic [atr_pkg::DATA_W-1:0]  i_conv_data,
   output logic                             o_rdy_dout,
   output logic                             o_int_osc_en,
   output logic                             o_sleep,
   output logic                             o_cal_busy
);

   atr_sclk_if                    ev ();
   atr_pkg::atr_state_t           state;
   logic [atr_pkg::DATA_W-1:0]    data_q;
   logic [atr_pkg::DATA_W-1:0]    shreg;
   logic [atr_pkg::CNT_W-1:0]     edges;
   logic                          pending;
   logic                          conv_done;
   logic                          tmr_run;
   logic                          start_conv;
   logic                          start_cal;
   logic                          ext_meta;
   logic                          ext_sync;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_asleep(input atr_pkg::atr_state_t s);
      return s == atr_pkg::ST_SLEEP || s == atr_pkg::ST_SLPCAL;
   endfunction

   // ----------------------------------------------------------------
   // shift clock events and interval timer
   // ----------------------------------------------------------------
   atr_sclk_sync #(
      .HOLD_CYC (HOLD_CYC)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_sclk    (i_sclk),
      .o_ev      (ev.src)
   );

   // the timer free-runs conversions except while asleep
   assign tmr_run    = !is_asleep(state);
   assign start_cal  = (state == atr_pkg::ST_PEND26 && ev.fall) ||
                       (state == atr_pkg::ST_SLPCAL && ev.fall);
   assign start_conv = (state == atr_pkg::ST_SLEEP && ev.fall) ||
                       (state == atr_pkg::ST_CAL && conv_done);

   atr_timer #(
      .CONV_CYC (CONV_CYC),
      .CAL_CYC  (CAL_CYC)
   ) u_tmr (
      .i_ref_clk    (i_ref_clk),
      .i_arst_n     (i_arst_n),
      .i_run        (tmr_run),
      .i_start_conv (start_conv),
      .i_start_cal  (start_cal),
      .o_done       (conv_done)
   );

   // ----------------------------------------------------------------
   // external clock detect, stops the internal oscillator
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end
      else
      begin
         ext_meta <= i_ext_clk_det;
         ext_sync <= ext_meta;
      end
   end

   assign o_int_osc_en = ~ext_sync;

   // ----------------------------------------------------------------
   // result holding register, newest conversion always wins
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         data_q <= '0;
      else if (conv_done && state != atr_pkg::ST_CAL)
         data_q <= i_conv_data;
   end

   // unread-result flag; a new result in the same cycle as a read start wins
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         pending <= 1'b0;
      else if (conv_done && state != atr_pkg::ST_CAL)
         pending <= 1'b1;
      else if ((state == atr_pkg::ST_READY && ev.rise) || is_asleep(state))
         pending <= 1'b0;
   end

   // ----------------------------------------------------------------
   // readout sequencer: state, output line, shifter and edge count
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         state      <= atr_pkg::ST_CAL;
         o_rdy_dout <= 1'b1;
         shreg      <= '0;
         edges      <= '0;
      end
      else
      begin
         case (state)
            atr_pkg::ST_CAL:
            begin
               o_rdy_dout <= 1'b1;
               if (conv_done)
                  state <= atr_pkg::ST_CONV;
            end
            atr_pkg::ST_CONV:
            begin
               o_rdy_dout <= 1'b1;
               if (conv_done)
               begin
                  state      <= atr_pkg::ST_READY;
                  o_rdy_dout <= 1'b0;
               end
            end
            atr_pkg::ST_READY:
            begin
               if (ev.rise)
               begin
                  o_rdy_dout <= data_q[atr_pkg::DATA_W-1];
                  shreg      <= {data_q[atr_pkg::DATA_W-2:0], 1'b0};
                  edges      <= 5'h01;
                  state      <= atr_pkg::ST_SHIFT;
               end
               else if (ev.long_high)
               begin
                  state      <= atr_pkg::ST_SLEEP;
                  o_rdy_dout <= 1'b1;
               end
               else
                  o_rdy_dout <= 1'b0;
            end
            atr_pkg::ST_SHIFT:
            begin
               if (ev.long_high)
               begin
                  state      <= atr_pkg::ST_SLEEP;
                  o_rdy_dout <= 1'b1;
               end
               else if (ev.rise && edges == atr_pkg::LAST_BIT_EDGE)
               begin
                  state      <= atr_pkg::ST_DONE;
                  o_rdy_dout <= 1'b1;
               end
               else if (ev.rise)
               begin
                  o_rdy_dout <= shreg[atr_pkg::DATA_W-1];
                  shreg      <= {shreg[atr_pkg::DATA_W-2:0], 1'b0};
                  edges      <= edges + 5'h01;
               end
            end
            atr_pkg::ST_DONE:
            begin
               o_rdy_dout <= 1'b1;
               if (ev.long_high)
                  state <= atr_pkg::ST_SLEEP;
               else if (ev.rise)
                  state <= atr_pkg::ST_PEND26;
               else if (pending || conv_done)
               begin
                  state      <= atr_pkg::ST_READY;
                  o_rdy_dout <= 1'b0;
               end
            end
            atr_pkg::ST_PEND26:
            begin
               o_rdy_dout <= 1'b1;
               if (ev.fall)
                  state <= atr_pkg::ST_CAL;
               else if (ev.long_high)
                  state <= atr_pkg::ST_SLPCAL;
            end
            atr_pkg::ST_SLPCAL:
            begin
               o_rdy_dout <= 1'b1;
               if (ev.fall)
                  state <= atr_pkg::ST_CAL;
            end
            atr_pkg::ST_SLEEP:
            begin
               o_rdy_dout <= 1'b1;
               if (ev.fall)
                  state <= atr_pkg::ST_CONV;
            end
            default:
            begin
               state      <= atr_pkg::ST_CAL;
               o_rdy_dout <= 1'b1;
            end
         endcase
      end
   end

   assign o_sleep    = is_asleep(state);
   assign o_cal_busy = (state == atr_pkg::ST_CAL);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_idle_high_level : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_CONV && $past(state) == atr_pkg::ST_CONV |-> o_rdy_dout)
      else $error("line not high while idle");

   chk_ready_goes_low : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_CONV && conv_done
      |=> !o_rdy_dout && state == atr_pkg::ST_READY)
      else $error("line not low after conversion");

   chk_msb_first_out : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_READY && ev.rise && !conv_done
      |=> o_rdy_dout == $past(data_q[atr_pkg::DATA_W-1]) ##0 edges == 5'h01)
      else $error("first edge did not show the msb");

   chk_next_bit_out : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_SHIFT && ev.rise && !ev.long_high
      && edges != atr_pkg::LAST_BIT_EDGE
      |=> o_rdy_dout == $past(shreg[atr_pkg::DATA_W-1]))
      else $error("shifted bit mismatch");

   chk_edge25_idle : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_SHIFT && ev.rise && !ev.long_high
      && edges == atr_pkg::LAST_BIT_EDGE
      |=> o_rdy_dout && state == atr_pkg::ST_DONE)
      else $error("25th edge did not return line high");

   chk_last_bit_hold : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_SHIFT && !ev.rise && !ev.long_high |=> $stable(o_rdy_dout))
      else $error("line moved without a shift edge");

   chk_result_overwrite : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      conv_done && state != atr_pkg::ST_CAL |=> data_q == $past(i_conv_data))
      else $error("new result did not replace old one");

   chk_cal_on_fall : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_PEND26 && ev.fall |=> state == atr_pkg::ST_CAL && o_cal_busy)
      else $error("26th falling edge did not start calibration");

   chk_sleep_entry : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (state == atr_pkg::ST_READY || state == atr_pkg::ST_SHIFT) && ev.long_high
      |=> o_sleep && o_rdy_dout)
      else $error("held clock did not enter sleep");

   chk_wake_restart : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_SLEEP && ev.fall |=> state == atr_pkg::ST_CONV ##1 !conv_done)
      else $error("wake did not restart conversion");

   chk_wake_cal : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      state == atr_pkg::ST_SLPCAL && ev.fall |=> o_cal_busy && !o_sleep)
      else $error("wake after held 26th did not calibrate");

   chk_osc_follows : assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_int_osc_en == !$past(ext_meta))
      else $error("oscillator enable does not follow the clock detect");

endmodule

// ---- tb/atr_host_model.sv ----
// host side model: drives the shift clock and reads the ready/data line
`timescale 1ns/100ps
module atr_host_model
(
   input  wire logic i_ref_clk,
   input  wire logic i_rdy_dout,
   output logic      o_sclk
);
   // shift clock stands low outside frames
   initial o_sclk = 1'b0;

   // ----------------------------------------------------------------
   // shift pulses: 200 ns high, 200 ns low, line sampled before next rise
   // ----------------------------------------------------------------
   task automatic pulse(output logic b);
      o_sclk = 1'b1;
      #200;
      o_sclk = 1'b0;
      #200;
      b = i_rdy_dout;
   endtask

   // reads n bits, fewer than 24 when sleep follows
   task automatic read(input int n, output logic [23:0] w);
      logic b;
      w = 24'h0;
      for (int k = 0; k < n; k++)
      begin
         pulse(b);
         w = {w[22:0], b};
      end
   endtask

   // no readout pulse before the line is seen low
   task automatic wait_ready(input int limit, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < limit && !ok; n++)
      begin
         @(posedge i_ref_clk);
         #5;
         ok = (i_rdy_dout === 1'b0);
      end
   endtask

   // ----------------------------------------------------------------
   // sleep entry by holding the clock high, wake by lowering it
   // ----------------------------------------------------------------
   task automatic hold(input int cyc);
      o_sclk = 1'b1;
      repeat (cyc) @(posedge i_ref_clk);
      #5;
   endtask

   task automatic wake();
      o_sclk = 1'b0;
   endtask
endmodule

// ---- tb/adc_two_wire_readout_test.sv ----
// self-checking bench of the two-wire readout sequencer
`timescale 1ns/100ps
module adc_two_wire_readout_test;
   localparam int unsigned CONV = 2000;
   localparam int unsigned CAL  = 100;
   localparam int unsigned HOLD = 20;
   localparam logic [23:0] DA   = 24'h3c96a5;
   localparam logic [23:0] DB   = 24'ha5c35a;
   localparam logic [23:0] DC   = 24'h81e7f0;

   logic        ref_clk = 1'b0;
   logic        arst_n;
   logic        sclk;
   logic        ext_det;
   logic [23:0] conv_data;
   logic        rdy_dout;
   logic        osc_en;
   logic        sleep;
   logic        cal_busy;
   logic [23:0] w;
   logic        b;
   int          mismatches = 0;
   int          compares = 0;

   always #25 ref_clk = ~ref_clk;

   atr_top #(.CONV_CYC(CONV), .CAL_CYC(CAL), .HOLD_CYC(HOLD)) i_atr_top
   (
      .i_ref_clk     (ref_clk),
      .i_arst_n      (arst_n),
      .i_sclk        (sclk),
      .i_ext_clk_det (ext_det),
      .i_conv_data   (conv_data),
      .o_rdy_dout    (rdy_dout),
      .o_int_osc_en  (osc_en),
      .o_sleep       (sleep),
      .o_cal_busy    (cal_busy)
   );

   atr_host_model i_atr_host_model
   (
      .i_ref_clk  (ref_clk),
      .i_rdy_dout (rdy_dout),
      .o_sclk     (sclk)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask

   task automatic wait_low(input int limit);
      logic ok;
      i_atr_host_model.wait_ready(limit, ok);
      compares++;
      if (!ok)
      begin
         mismatches++;
         $display("[FAIL] ready low expected 0 seen 1");
         wrap_up();
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      tick(2);
      check("rdy in reset", rdy_dout, 1'b1);
      check("cal in reset", cal_busy, 1'b1);
      tick(3);
      arst_n = 1'b1;
      i_atr_host_model.pulse(b);
      i_atr_host_model.pulse(b);
      check("rdy ignores sclk", b, 1'b1);
      check("cal after reset", cal_busy, 1'b1);
      wait_low(CAL + CONV + 50);
      check("cal over", cal_busy, 1'b0);
   endtask

   task automatic t_read_overwrite();
      conv_data = DB;
      tick(CONV + 20);
      check("rdy held low", rdy_dout, 1'b0);
      i_atr_host_model.read(24, w);
      check("word", w, DB);
      tick(20);
      check("last bit stands", rdy_dout, DB[0]);
      i_atr_host_model.pulse(b);
      check("25th pulse", b, 1'b1);
      i_atr_host_model.pulse(b);
      check("26th cal", cal_busy, 1'b1);
      check("rdy in cal", rdy_dout, 1'b1);
      wait_low(CAL + CONV + 50);
      check("cal done", cal_busy, 1'b0);
   endtask

   task automatic t_sleep();
      i_atr_host_model.read(5, w);
      check("partial", w, {19'h0, DB[23:19]});
      i_atr_host_model.hold(HOLD / 2);
      check("short high", sleep, 1'b0);
      i_atr_host_model.hold(HOLD);
      check("sleep", sleep, 1'b1);
      check("rdy sleep", rdy_dout, 1'b1);
      conv_data = DC;
      i_atr_host_model.wake();
      tick(6);
      check("woken", sleep, 1'b0);
      check("no cal", cal_busy, 1'b0);
      wait_low(CONV + 50);
      i_atr_host_model.read(24, w);
      check("word after wake", w, DC);
   endtask

   task automatic t_wake_cal();
      i_atr_host_model.pulse(b);
      check("25th high", b, 1'b1);
      wait_low(CONV + 50);
      i_atr_host_model.read(24, w);
      check("word before cal", w, DC);
      i_atr_host_model.pulse(b);
      i_atr_host_model.hold(2 * HOLD);
      check("held 26th sleep", sleep, 1'b1);
      check("no cal yet", cal_busy, 1'b0);
      i_atr_host_model.wake();
      tick(6);
      check("wake cal", cal_busy, 1'b1);
      check("rdy high cal", rdy_dout, 1'b1);
      wait_low(CAL + CONV + 50);
   endtask

   task automatic t_sleep25();
      i_atr_host_model.read(24, w);
      check("word after cal", w, DC);
      i_atr_host_model.hold(2 * HOLD);
      check("held 25th sleep", sleep, 1'b1);
      check("rdy 25th sleep", rdy_dout, 1'b1);
      i_atr_host_model.wake();
      tick(6);
      check("plain wake", cal_busy, 1'b0);
      wait_low(CONV + 50);
   endtask

   task automatic t_ext_clk();
      ext_det = 1'b1;
      tick(4);
      check("osc off", osc_en, 1'b0);
      ext_det = 1'b0;
      tick(4);
      check("osc on", osc_en, 1'b1);
   endtask

   initial
   begin
      arst_n = 1'b0;
      ext_det = 1'b0;
      conv_data = DA;
      t_reset();
      t_read_overwrite();
      t_sleep();
      t_wake_cal();
      t_sleep25();
      t_ext_clk();
      wrap_up();
   end
endmodule
